// ### logic/crs_consts.vh
// Offsets, field positions, reset values, codes and counts of the register set
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

// Avalon-MM byte addresses, one aligned 32-bit word each
`define CRS_ADDR_ACC 6'h00
`define CRS_ADDR_INDEX 6'h04
`define CRS_ADDR_SP 6'h08
`define CRS_ADDR_PC 6'h0c
`define CRS_ADDR_FLAGS 6'h10
`define CRS_ADDR_OPER 6'h14
`define CRS_ADDR_CMD 6'h18
`define CRS_ADDR_STATUS 6'h1c
`define CRS_ADDR_CTRL 6'h20
`define CRS_ADDR_EA 6'h24

// Condition flag bit positions
`define CRS_BIT_V 7
`define CRS_BIT_ONE6 6
`define CRS_BIT_ONE5 5
`define CRS_BIT_H 4
`define CRS_BIT_I 3
`define CRS_BIT_N 2
`define CRS_BIT_Z 1
`define CRS_BIT_C 0

// Status and control bit positions
`define CRS_ST_BUSY 0
`define CRS_ST_WAIT 1
`define CRS_ST_STOP 2
`define CRS_ST_BRK 3
`define CRS_CTRL_BRK_EN 0

// Reset values and vectors
`define CRS_SP_RST 16'h00ff
`define CRS_SP_LOW_RST 8'hff
`define CRS_VEC_RESET 16'hfffe
`define CRS_VEC_SWI 16'hfffc
`define CRS_VEC_SWI_MON 16'hfefc
`define CRS_VEC_IRQ0 16'hfffa

// Oscillator stabilisation delay after stop, in bus clock cycles
`define CRS_OSC_STAB_CYC 13'h1000

// Command codes written to the command register
`define CRS_OP_NOP 5'h00
`define CRS_OP_ADD 5'h01
`define CRS_OP_ADC 5'h02
`define CRS_OP_SUB 5'h03
`define CRS_OP_SBC 5'h04
`define CRS_OP_AND 5'h05
`define CRS_OP_ORA 5'h06
`define CRS_OP_EOR 5'h07
`define CRS_OP_LDA 5'h08
`define CRS_OP_LSL 5'h09
`define CRS_OP_LSR 5'h0a
`define CRS_OP_ROL 5'h0b
`define CRS_OP_ROR 5'h0c
`define CRS_OP_DAA 5'h0d
`define CRS_OP_PSHA 5'h0e
`define CRS_OP_PULA 5'h0f
`define CRS_OP_PUSH_INDEX_HIGH 5'h10
`define CRS_OP_PULL_INDEX_HIGH 5'h11
`define CRS_OP_RSP 5'h12
`define CRS_OP_CLI 5'h13
`define CRS_OP_SEI 5'h14
`define CRS_OP_SWI 5'h15
`define CRS_OP_RTI 5'h16
`define CRS_OP_WAIT 5'h17
`define CRS_OP_STOP 5'h18
`define CRS_OP_JMP 5'h19
`define CRS_OP_FETCH 5'h1a
`define CRS_OP_BLT 5'h1b
`define CRS_OP_BGE 5'h1c
`define CRS_OP_LDHX 5'h1d
`define CRS_OP_EASP 5'h1e
`define CRS_OP_EAIX 5'h1f

`endif

// ### logic/crs_regset.v
// CPU register set with flags, stack sequencer, low-power and break entry
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.vh"

module crs_regset #(
   parameter [12:0] OSC_STAB_CYC = `CRS_OSC_STAB_CYC
) (
   input wire clock,
   input wire srst,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_wr,
   output reg mem_rd,
   input wire [7:0] mem_rdata,
   input wire [3:0] irq_req,
   input wire break_req,
   input wire monitor_mode,
   output wire cpu_clk_run
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_PUSH = 3'h1;
   localparam [2:0] S_PULL = 3'h2;
   localparam [2:0] S_VEC = 3'h3;
   localparam [2:0] S_WAIT = 3'h4;
   localparam [2:0] S_STOP = 3'h5;
   localparam [2:0] S_STAB = 3'h6;

   localparam [2:0] K_ENTRY = 3'h0;
   localparam [2:0] K_RTI = 3'h1;
   localparam [2:0] K_PSHA = 3'h2;
   localparam [2:0] K_PULA = 3'h3;
   localparam [2:0] K_PUSH_INDEX_HIGH = 3'h4;
   localparam [2:0] K_PULL_INDEX_HIGH = 3'h5;
   localparam [2:0] K_RESET = 3'h6;

   localparam [12:0] STAB_LOAD = OSC_STAB_CYC - 13'h0001;

   reg [7:0] acc_r;
   reg [7:0] idx_hi_r;
   reg [7:0] idx_lo_r;
   reg [15:0] sp_r;
   reg [15:0] pc_r;
   reg v_r, h_r, i_r, n_r, z_r, c_r;
   reg [15:0] oper_r;
   reg [15:0] ea_r;
   reg brk_en_r;
   reg brk_act_r;
   reg [2:0] state_r;
   reg [2:0] kind_r;
   reg [2:0] step_r;
   reg [15:0] vec_r;
   reg [12:0] stab_r;
   reg rd_done_r;
   reg [5:0] sync1_r;
   reg [5:0] sync2_r;

   wire [3:0] irq_s = sync2_r[3:0];
   wire brk_s = sync2_r[4];
   wire mon_s = sync2_r[5];
   wire [7:0] flags = {v_r, 1'b1, 1'b1, h_r, i_r, n_r, z_r, c_r};
   wire [4:0] cmd = avs_writedata[4:0];
   wire take_brk = brk_en_r & brk_s & ~brk_act_r;
   wire take_irq = ~i_r & (|irq_s);
   wire wr_ok = (state_r == S_IDLE) & ~take_brk & ~take_irq;
   wire [15:0] brk_vec = mon_s ? `CRS_VEC_SWI_MON : `CRS_VEC_SWI;
   wire [2:0] pull_last = (kind_r == K_RTI) ? 3'h6 : 3'h2;
   wire [2:0] pull_cnt = (kind_r == K_RTI) ? 3'h5 : 3'h1;
   wire [2:0] cap_idx = step_r - 3'h2;
   wire [15:0] rel16 = {{8{oper_r[7]}}, oper_r[7:0]};

   assign avs_waitrequest = (avs_write & ~wr_ok) | (avs_read & ~rd_done_r);
   assign cpu_clk_run = (state_r != S_WAIT) & (state_r != S_STOP) &
                        (state_r != S_STAB);

   // Lower request number is the higher priority
   reg [1:0] irq_idx;
   integer k;
   always @* begin
      irq_idx = 2'h0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (irq_s[k]) begin
            irq_idx = k[1:0];
         end
      end
   end
   wire [15:0] irq_vec = `CRS_VEC_IRQ0 - {13'h0000, irq_idx, 1'b0};

   // Arithmetic and logic on the accumulator and the operand low byte
   reg [7:0] alu_res;
   reg alu_v, alu_h, alu_c, alu_hit;
   reg [8:0] sum9;
   reg [4:0] nib5;
   reg cin;
   reg [7:0] adj;
   wire [7:0] bop = oper_r[7:0];
   always @* begin
      alu_res = acc_r;
      alu_v = v_r;
      alu_h = h_r;
      alu_c = c_r;
      alu_hit = 1'b1;
      sum9 = 9'h000;
      nib5 = 5'h00;
      adj = 8'h00;
      cin = ((cmd == `CRS_OP_ADC) | (cmd == `CRS_OP_SBC)) & c_r;
      case (cmd)
         `CRS_OP_ADD, `CRS_OP_ADC: begin
            sum9 = {1'b0, acc_r} + {1'b0, bop} + {8'h00, cin};
            nib5 = {1'b0, acc_r[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
            alu_res = sum9[7:0];
            alu_c = sum9[8];
            alu_h = nib5[4];
            alu_v = (acc_r[7] & bop[7] & ~sum9[7]) |
                    (~acc_r[7] & ~bop[7] & sum9[7]);
         end
         `CRS_OP_SUB, `CRS_OP_SBC: begin
            sum9 = {1'b0, acc_r} - {1'b0, bop} - {8'h00, cin};
            alu_res = sum9[7:0];
            alu_c = sum9[8];
            alu_v = (acc_r[7] & ~bop[7] & ~sum9[7]) |
                    (~acc_r[7] & bop[7] & sum9[7]);
         end
         `CRS_OP_AND: begin
            alu_res = acc_r & bop;
            alu_v = 1'b0;
         end
         `CRS_OP_ORA: begin
            alu_res = acc_r | bop;
            alu_v = 1'b0;
         end
         `CRS_OP_EOR: begin
            alu_res = acc_r ^ bop;
            alu_v = 1'b0;
         end
         `CRS_OP_LDA: begin
            alu_res = bop;
            alu_v = 1'b0;
         end
         `CRS_OP_LSL: begin
            alu_res = {acc_r[6:0], 1'b0};
            alu_c = acc_r[7];
            alu_v = acc_r[6] ^ acc_r[7];
         end
         `CRS_OP_LSR: begin
            alu_res = {1'b0, acc_r[7:1]};
            alu_c = acc_r[0];
            alu_v = acc_r[0];
         end
         `CRS_OP_ROL: begin
            alu_res = {acc_r[6:0], c_r};
            alu_c = acc_r[7];
            alu_v = acc_r[6] ^ acc_r[7];
         end
         `CRS_OP_ROR: begin
            alu_res = {c_r, acc_r[7:1]};
            alu_c = acc_r[0];
            alu_v = c_r ^ acc_r[0];
         end
         `CRS_OP_DAA: begin
            // Correction picked from half-carry and carry
            adj = {((c_r | (acc_r > 8'h99)) ? 4'h6 : 4'h0),
                   ((h_r | (acc_r[3:0] > 4'h9)) ? 4'h6 : 4'h0)};
            alu_res = acc_r + adj;
            alu_c = c_r | (acc_r > 8'h99);
         end
         default: begin
            alu_hit = 1'b0;
         end
      endcase
   end

   // Byte sent to the stack on each push step
   reg [7:0] push_byte;
   always @* begin
      push_byte = acc_r;
      case (kind_r)
         K_ENTRY: begin
            // Index high byte is deliberately not stacked
            case (step_r)
               3'h0: push_byte = pc_r[7:0];
               3'h1: push_byte = pc_r[15:8];
               3'h2: push_byte = idx_lo_r;
               3'h3: push_byte = acc_r;
               default: push_byte = flags;
            endcase
         end
         K_PUSH_INDEX_HIGH: push_byte = idx_hi_r;
         default: push_byte = acc_r;
      endcase
   end

   // Registered bus read data, one wait cycle per read
   reg [31:0] rd_mux;
   always @* begin
      case (avs_address)
         `CRS_ADDR_ACC: rd_mux = {24'h000000, acc_r};
         `CRS_ADDR_INDEX: rd_mux = {16'h0000, idx_hi_r, idx_lo_r};
         `CRS_ADDR_SP: rd_mux = {16'h0000, sp_r};
         `CRS_ADDR_PC: rd_mux = {16'h0000, pc_r};
         `CRS_ADDR_FLAGS: rd_mux = {24'h000000, flags};
         `CRS_ADDR_OPER: rd_mux = {16'h0000, oper_r};
         `CRS_ADDR_STATUS: rd_mux = {24'h000000, irq_s, brk_act_r,
                                     state_r == S_STOP || state_r == S_STAB,
                                     state_r == S_WAIT,
                                     state_r != S_IDLE};
         `CRS_ADDR_CTRL: rd_mux = {31'h00000000, brk_en_r};
         `CRS_ADDR_EA: rd_mux = {16'h0000, ea_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clock) begin
      sync1_r <= {monitor_mode, break_req, irq_req};
      sync2_r <= sync1_r;
   end

   task start_entry;
      input [15:0] vec;
      begin
         state_r <= S_PUSH;
         kind_r <= K_ENTRY;
         step_r <= 3'h0;
         vec_r <= vec;
      end
   endtask

   task start_seq;
      input [2:0] st;
      input [2:0] kind;
      begin
         state_r <= st;
         kind_r <= kind;
         step_r <= 3'h0;
      end
   endtask

   always @(posedge clock) begin
      if (srst) begin
         acc_r <= 8'h00;
         idx_hi_r <= 8'h00;
         idx_lo_r <= 8'h00;
         sp_r <= `CRS_SP_RST;
         pc_r <= 16'h0000;
         {v_r, h_r, n_r, z_r, c_r} <= 5'h00;
         i_r <= 1'b1;
         oper_r <= 16'h0000;
         ea_r <= 16'h0000;
         brk_en_r <= 1'b0;
         brk_act_r <= 1'b0;
         state_r <= S_VEC;
         kind_r <= K_RESET;
         step_r <= 3'h0;
         vec_r <= `CRS_VEC_RESET;
         stab_r <= 13'h0000;
         rd_done_r <= 1'b0;
         avs_readdata <= 32'h00000000;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
      end else begin
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         rd_done_r <= avs_read & ~rd_done_r;
         if (avs_read & ~rd_done_r) begin
            avs_readdata <= rd_mux;
         end
         case (state_r)
            S_IDLE: begin
               if (take_brk) begin
                  brk_act_r <= 1'b1;
                  start_entry(brk_vec);
               end else if (take_irq) begin
                  start_entry(irq_vec);
               end else if (avs_write) begin
                  case (avs_address)
                     `CRS_ADDR_ACC: acc_r <= avs_writedata[7:0];
                     `CRS_ADDR_INDEX: begin
                        idx_hi_r <= avs_writedata[15:8];
                        idx_lo_r <= avs_writedata[7:0];
                     end
                     `CRS_ADDR_SP: sp_r <= avs_writedata[15:0];
                     `CRS_ADDR_PC: pc_r <= avs_writedata[15:0];
                     `CRS_ADDR_FLAGS: begin
                        v_r <= avs_writedata[`CRS_BIT_V];
                        h_r <= avs_writedata[`CRS_BIT_H];
                        n_r <= avs_writedata[`CRS_BIT_N];
                        z_r <= avs_writedata[`CRS_BIT_Z];
                        c_r <= avs_writedata[`CRS_BIT_C];
                        // A plain write may set the mask, never clear it
                        i_r <= i_r | avs_writedata[`CRS_BIT_I];
                     end
                     `CRS_ADDR_OPER: oper_r <= avs_writedata[15:0];
                     `CRS_ADDR_CTRL: brk_en_r <= avs_writedata[`CRS_CTRL_BRK_EN];
                     `CRS_ADDR_CMD: begin
                        if (alu_hit) begin
                           acc_r <= alu_res;
                           v_r <= alu_v;
                           h_r <= alu_h;
                           c_r <= alu_c;
                           n_r <= alu_res[7];
                           z_r <= (alu_res == 8'h00);
                        end
                        case (cmd)
                           `CRS_OP_PSHA: start_seq(S_PUSH, K_PSHA);
                           `CRS_OP_PULA: start_seq(S_PULL, K_PULA);
                           `CRS_OP_PUSH_INDEX_HIGH: start_seq(S_PUSH, K_PUSH_INDEX_HIGH);
                           `CRS_OP_PULL_INDEX_HIGH: start_seq(S_PULL, K_PULL_INDEX_HIGH);
                           `CRS_OP_RSP: sp_r[7:0] <= `CRS_SP_LOW_RST;
                           `CRS_OP_CLI: i_r <= 1'b0;
                           `CRS_OP_SEI: i_r <= 1'b1;
                           `CRS_OP_SWI: start_entry(`CRS_VEC_SWI);
                           `CRS_OP_RTI: start_seq(S_PULL, K_RTI);
                           `CRS_OP_WAIT: begin
                              i_r <= 1'b0;
                              state_r <= S_WAIT;
                           end
                           `CRS_OP_STOP: begin
                              i_r <= 1'b0;
                              state_r <= S_STOP;
                           end
                           `CRS_OP_JMP: pc_r <= oper_r;
                           `CRS_OP_FETCH: pc_r <= pc_r + 16'h0001;
                           `CRS_OP_BLT: begin
                              if (n_r ^ v_r) begin
                                 pc_r <= pc_r + rel16;
                              end
                           end
                           `CRS_OP_BGE: begin
                              if (~(n_r ^ v_r)) begin
                                 pc_r <= pc_r + rel16;
                              end
                           end
                           `CRS_OP_LDHX: begin
                              idx_hi_r <= oper_r[15:8];
                              idx_lo_r <= oper_r[7:0];
                           end
                           `CRS_OP_EASP: ea_r <= sp_r + oper_r;
                           `CRS_OP_EAIX: ea_r <= {idx_hi_r, idx_lo_r} + oper_r;
                           default: ea_r <= ea_r;
                        endcase
                     end
                     default: ea_r <= ea_r;
                  endcase
               end
            end
            S_PUSH: begin
               // Write at the stack pointer, then move it down
               mem_wr <= 1'b1;
               mem_addr <= sp_r;
               mem_wdata <= push_byte;
               sp_r <= sp_r - 16'h0001;
               step_r <= step_r + 3'h1;
               if (kind_r != K_ENTRY) begin
                  state_r <= S_IDLE;
               end else if (step_r == 3'h4) begin
                  // Mask goes up after stacking, before the vector fetch
                  i_r <= 1'b1;
                  state_r <= S_VEC;
                  step_r <= 3'h0;
               end
            end
            S_VEC: begin
               // Memory answers in the cycle after the read strobe
               step_r <= step_r + 3'h1;
               if (step_r == 3'h0) begin
                  mem_rd <= 1'b1;
                  mem_addr <= vec_r;
               end
               if (step_r == 3'h1) begin
                  mem_rd <= 1'b1;
                  mem_addr <= vec_r + 16'h0001;
               end
               if (step_r == 3'h2) begin
                  pc_r[15:8] <= mem_rdata;
               end
               if (step_r == 3'h3) begin
                  pc_r[7:0] <= mem_rdata;
                  state_r <= S_IDLE;
               end
            end
            S_PULL: begin
               step_r <= step_r + 3'h1;
               if (step_r < pull_cnt) begin
                  mem_rd <= 1'b1;
                  mem_addr <= sp_r + 16'h0001;
                  sp_r <= sp_r + 16'h0001;
               end
               if (step_r >= 3'h2) begin
                  if (kind_r == K_RTI) begin
                     case (cap_idx)
                        3'h0: begin
                           v_r <= mem_rdata[`CRS_BIT_V];
                           h_r <= mem_rdata[`CRS_BIT_H];
                           i_r <= mem_rdata[`CRS_BIT_I];
                           n_r <= mem_rdata[`CRS_BIT_N];
                           z_r <= mem_rdata[`CRS_BIT_Z];
                           c_r <= mem_rdata[`CRS_BIT_C];
                        end
                        3'h1: acc_r <= mem_rdata;
                        3'h2: idx_lo_r <= mem_rdata;
                        3'h3: pc_r[15:8] <= mem_rdata;
                        default: pc_r[7:0] <= mem_rdata;
                     endcase
                  end else if (kind_r == K_PULL_INDEX_HIGH) begin
                     idx_hi_r <= mem_rdata;
                  end else begin
                     acc_r <= mem_rdata;
                  end
               end
               if (step_r == pull_last) begin
                  state_r <= S_IDLE;
                  if ((kind_r == K_RTI) & ~brk_s) begin
                     brk_act_r <= 1'b0;
                  end
               end
            end
            S_WAIT: begin
               // Stacked flags hold the clear mask, so return resumes clear
               if (|irq_s) begin
                  start_entry(irq_vec);
               end
            end
            S_STOP: begin
               if (|irq_s) begin
                  state_r <= S_STAB;
                  stab_r <= STAB_LOAD;
               end
            end
            S_STAB: begin
               // A request withdrawn during the delay resumes without entry
               stab_r <= stab_r - 13'h0001;
               if (stab_r == 13'h0000) begin
                  if (|irq_s) begin
                     start_entry(irq_vec);
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

endmodule // crs_regset
`default_nettype wire

// ### testbench/crs_regset_assertions.sv
// Concurrent checks on the register set ports
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.vh"
module crs_regset_assertions #(
   parameter [12:0] OSC_STAB_CYC = `CRS_OSC_STAB_CYC
) (
   input wire clock,
   input wire srst,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [15:0] mem_addr,
   input wire [7:0] mem_wdata,
   input wire mem_wr,
   input wire mem_rd,
   input wire [7:0] mem_rdata,
   input wire [3:0] irq_req,
   input wire break_req,
   input wire monitor_mode,
   input wire cpu_clk_run
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_one_push;
      mem_wr ##1 !mem_wr;
   endsequence
   // Entry stacks five bytes, never the index high byte
   sequence s_entry_push;
      mem_wr [*5] ##1 !mem_wr;
   endsequence
   chk_read_wait: assert property ($rose(avs_read) |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait cycle wrong");
   chk_flag_ones: assert property (avs_read && !avs_waitrequest &&
      avs_address == `CRS_ADDR_FLAGS |-> avs_readdata[6:5] == 2'b11)
      else $error("flag bits 6 and 5 not one");
   chk_reset_vector: assert property ($fell(srst) |-> ##[0:2]
      (mem_rd && mem_addr == 16'hfffe) ##1 (mem_rd && mem_addr == 16'hffff))
      else $error("reset vector fetch wrong");
   chk_push_down: assert property (mem_wr && $past(mem_wr) |->
      mem_addr == $past(mem_addr) - 16'h0001)
      else $error("push address did not decrement");
   chk_pull_up: assert property (mem_rd && $past(mem_rd) |->
      mem_addr == $past(mem_addr) + 16'h0001)
      else $error("read address did not increment");
   chk_push_count: assert property ($rose(mem_wr) |->
      s_one_push or s_entry_push)
      else $error("push burst length wrong");
   chk_entry_vector: assert property (s_entry_push |-> ##[0:3]
      (mem_rd && mem_addr[15:9] == 7'h7f && !mem_addr[0]))
      else $error("no vector fetch after stacking");
   chk_clock_reset: assert property ($fell(srst) |-> cpu_clk_run)
      else $error("clock not running after reset");
   chk_sleep_stall: assert property (!cpu_clk_run && avs_write |->
      avs_waitrequest)
      else $error("write accepted while clock stopped");
endmodule // crs_regset_assertions
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the register set over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.vh"
`define CHK(nm, exp, got) \
   checks_done++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
   end
module testbench;
   logic clock, srst, avs_read, avs_write, avs_waitrequest, break_req;
   logic mem_wr, mem_rd, monitor_mode, cpu_clk_run;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [15:0] mem_addr, pc0;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata = 8'h00;
   logic [3:0] irq_req;
   logic [7:0] mem [0:65535];
   int mismatches = 0;
   int checks_done = 0;
   crs_regset #(.OSC_STAB_CYC(13'h0008)) crs_regset_i (.clock(clock),
      .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .irq_req(irq_req),
      .break_req(break_req), .monitor_mode(monitor_mode),
      .cpu_clk_run(cpu_clk_run));
   // Stack memory answers one cycle after the read strobe
   always @(posedge clock) begin
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      if (mem_rd) mem_rdata <= mem[mem_addr];
   end
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic print_verdict;
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic rw, input [5:0] a, input [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= rw;
      avs_read <= !rw;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 3000);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 3000) begin
         mismatches++;
         print_verdict();
      end
   endtask
   task automatic wr(input [5:0] a, input [31:0] wd);
      bus(1'b1, a, wd);
   endtask
   task automatic rd(input [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   // Second write stalls until the sequencer is idle again
   task automatic cmd(input [4:0] op);
      wr(`CRS_ADDR_CMD, {27'h0, op});
      wr(6'h3c, 32'h0);
   endtask
   task automatic alu(input [4:0] op, input [7:0] a, b, r, f);
      wr(`CRS_ADDR_ACC, {24'h0, a});
      wr(`CRS_ADDR_OPER, {24'h0, b});
      cmd(op);
      rd(`CRS_ADDR_ACC);
      `CHK("acc", r, d[7:0])
      rd(`CRS_ADDR_FLAGS);
      `CHK("flags", f, d[7:0])
   endtask
   initial begin
      srst = 1'b1;
      {avs_read, avs_write, break_req, monitor_mode} = 4'h0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      irq_req = 4'h0;
      {mem[16'hfffe], mem[16'hffff], mem[16'hfffc], mem[16'hfffd]} = 32'h1234abcd;
      {mem[16'hfff8], mem[16'hfff9], mem[16'hfff4], mem[16'hfff5]} = 32'h56783c5a;
      {mem[16'hfefc], mem[16'hfefd]} = 16'h9abc;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h00ff, d[15:0])
      rd(`CRS_ADDR_PC); `CHK("pc", 16'h1234, d[15:0])
      wr(`CRS_ADDR_FLAGS, 32'h0);
      rd(`CRS_ADDR_FLAGS); `CHK("flags", 8'h68, d[7:0])
      rd(6'h3c); `CHK("unmapped", 32'h0, d)
      alu(`CRS_OP_ADD, 8'h08, 8'h08, 8'h10, 8'h78);
      alu(`CRS_OP_ADD, 8'h80, 8'h80, 8'h00, 8'heb);
      alu(`CRS_OP_ADC, 8'h00, 8'h00, 8'h01, 8'h68);
      alu(`CRS_OP_SUB, 8'h00, 8'h01, 8'hff, 8'h6d);
      alu(`CRS_OP_ADD, 8'h7f, 8'h01, 8'h80, 8'hfc);
      // Decimal adjust relies on the half-carry left by the add above
      alu(`CRS_OP_DAA, 8'h10, 8'h00, 8'h16, 8'hf8);
      alu(`CRS_OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h7a);
      alu(`CRS_OP_LSL, 8'h81, 8'h00, 8'h02, 8'hf9);
      wr(`CRS_ADDR_ACC, 32'h5a);
      cmd(`CRS_OP_PSHA);
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h00fe, d[15:0])
      // Memory is looked at only once its last write edge has settled
      `CHK("pushed", 8'h5a, mem[16'h00ff])
      wr(`CRS_ADDR_ACC, 32'h0);
      cmd(`CRS_OP_PULA);
      rd(`CRS_ADDR_ACC); `CHK("acc", 8'h5a, d[7:0])
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h00ff, d[15:0])
      wr(`CRS_ADDR_SP, 32'h1234);
      cmd(`CRS_OP_RSP);
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h12ff, d[15:0])
      wr(`CRS_ADDR_SP, 32'h00ff);
      wr(`CRS_ADDR_OPER, 32'h4000);
      cmd(`CRS_OP_JMP);
      cmd(`CRS_OP_FETCH);
      rd(`CRS_ADDR_PC); `CHK("pc", 16'h4001, d[15:0])
      cmd(`CRS_OP_EASP);
      rd(`CRS_ADDR_EA); `CHK("ea", 16'h40ff, d[15:0])
      wr(`CRS_ADDR_FLAGS, 32'h0);
      cmd(`CRS_OP_CLI);
      wr(`CRS_ADDR_ACC, 32'h11);
      wr(`CRS_ADDR_INDEX, 32'h2233);
      rd(`CRS_ADDR_INDEX); `CHK("index", 16'h2233, d[15:0])
      cmd(`CRS_OP_SWI);
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h00fa, d[15:0])
      `CHK("stack", 24'h331160, {mem[16'hfd], mem[16'hfc], mem[16'hfb]})
      rd(`CRS_ADDR_PC); `CHK("pc", 16'habcd, d[15:0])
      rd(`CRS_ADDR_FLAGS); `CHK("mask", 1'b1, d[3])
      cmd(`CRS_OP_RTI);
      rd(`CRS_ADDR_FLAGS); `CHK("flags", 8'h60, d[7:0])
      rd(`CRS_ADDR_SP); `CHK("sp", 16'h00ff, d[15:0])
      cmd(`CRS_OP_PUSH_INDEX_HIGH);
      wr(`CRS_ADDR_INDEX, 32'h0);
      cmd(`CRS_OP_PULL_INDEX_HIGH);
      rd(`CRS_ADDR_INDEX); `CHK("index", 16'h2200, d[15:0])
      cmd(`CRS_OP_SEI);
      rd(`CRS_ADDR_PC);
      pc0 = d[15:0];
      irq_req <= 4'b0110;
      repeat (4) @(posedge clock);
      wr(6'h3c, 32'h0);
      rd(`CRS_ADDR_PC); `CHK("pc", pc0, d[15:0])
      cmd(`CRS_OP_CLI);
      rd(`CRS_ADDR_PC); `CHK("pc", 16'h5678, d[15:0])
      irq_req <= 4'h0;
      wr(`CRS_ADDR_CMD, {27'h0, `CRS_OP_WAIT});
      repeat (2) @(posedge clock);
      `CHK("run", 1'b0, cpu_clk_run)
      rd(`CRS_ADDR_FLAGS); `CHK("mask", 1'b0, d[3])
      rd(`CRS_ADDR_STATUS); `CHK("wait", 1'b1, d[1])
      irq_req <= 4'b1000;
      wr(6'h3c, 32'h0);
      rd(`CRS_ADDR_PC); `CHK("pc", 16'h3c5a, d[15:0])
      irq_req <= 4'h0;
      wr(`CRS_ADDR_CTRL, 32'h1);
      monitor_mode <= 1'b1;
      break_req <= 1'b1;
      repeat (4) @(posedge clock);
      wr(6'h3c, 32'h0);
      rd(`CRS_ADDR_PC); `CHK("pc", 16'h9abc, d[15:0])
      rd(`CRS_ADDR_STATUS); `CHK("brk", 1'b1, d[3])
      break_req <= 1'b0;
      repeat (4) @(posedge clock);
      cmd(`CRS_OP_RTI);
      rd(`CRS_ADDR_STATUS); `CHK("brk", 1'b0, d[3])
      wr(`CRS_ADDR_CMD, {27'h0, `CRS_OP_STOP});
      repeat (2) @(posedge clock);
      rd(`CRS_ADDR_STATUS); `CHK("stop", 1'b1, d[2])
      rd(`CRS_ADDR_FLAGS); `CHK("mask", 1'b0, d[3])
      srst <= 1'b1;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      rd(`CRS_ADDR_FLAGS); `CHK("flags", 8'h68, d[7:0])
      print_verdict();
   end
endmodule // testbench
bind crs_regset crs_regset_assertions #(.OSC_STAB_CYC(OSC_STAB_CYC)) chk_i (
   .clock(clock), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
   .mem_rd(mem_rd), .mem_rdata(mem_rdata), .irq_req(irq_req),
   .break_req(break_req), .monitor_mode(monitor_mode),
   .cpu_clk_run(cpu_clk_run));
`default_nettype wire
